//--- rtl/crs_pkg.sv
// Purpose: Shared constants and carrier types of the core register set
// Assumes: 32-bit registers, byte addressed register bus
// Notes:   Bus offsets are byte addresses of aligned words
package crs_pkg;

  localparam int unsigned CRS_DATA_W   = 32;
  localparam int unsigned CRS_GPR_NUM  = 16;
  localparam int unsigned CRS_IDX_W    = 4;
  localparam int unsigned CRS_ADDR_W   = 8;

  // Fixed roles inside the general register bank
  localparam logic [3:0] CRS_INDEX_GPR = 4'h0;
  localparam logic [3:0] CRS_STACK_GPR = 4'hf;

  // Register bus map
  localparam logic [7:0] CRS_OFS_GPR_BASE = 8'h00;
  localparam logic [7:0] CRS_OFS_GPR_LAST = 8'h3c;
  localparam logic [7:0] CRS_OFS_STATUS   = 8'h40;
  localparam logic [7:0] CRS_OFS_GLOBAL   = 8'h44;
  localparam logic [7:0] CRS_OFS_VECTOR   = 8'h48;
  localparam logic [7:0] CRS_OFS_MACHI    = 8'h4c;
  localparam logic [7:0] CRS_OFS_MACLO    = 8'h50;
  localparam logic [7:0] CRS_OFS_LINK     = 8'h54;
  localparam logic [7:0] CRS_OFS_PC       = 8'h58;
  localparam logic [7:0] CRS_OFS_CORESTAT = 8'h5c;

  // Status word layout
  localparam int unsigned CRS_SW_MASK_LSB = 4;
  localparam logic [31:0] CRS_SW_IMPL     = 32'h0000_03f3;
  localparam logic [31:0] CRS_SW_RESET    = 32'h0000_00f0;

  // Reset values
  localparam logic [31:0] CRS_VECTOR_RESET = 32'h0000_0000;
  localparam logic [31:0] CRS_ZERO         = 32'h0000_0000;

  // Vector table slots used at reset and stack frame geometry
  localparam logic [31:0] CRS_VEC_PC_ADDR  = 32'h0000_0000;
  localparam logic [31:0] CRS_VEC_SP_ADDR  = 32'h0000_0004;
  localparam logic [31:0] CRS_WORD_BYTES   = 32'h0000_0004;
  localparam logic [31:0] CRS_FRAME_BYTES  = 32'h0000_0008;

  typedef enum logic [1:0] {
    CRS_ST_FETCH_PC = 2'b00,
    CRS_ST_FETCH_SP = 2'b01,
    CRS_ST_RUN      = 2'b10
  } crs_state_t;

  typedef enum logic [2:0] {
    CRS_SEL_STATUS = 3'b000,
    CRS_SEL_GLOBAL = 3'b001,
    CRS_SEL_VECTOR = 3'b010,
    CRS_SEL_MACHI  = 3'b011,
    CRS_SEL_MACLO  = 3'b100,
    CRS_SEL_LINK   = 3'b101
  } crs_sel_t;

  typedef struct packed {
    logic [3:0]  idx;
    logic [31:0] data;
    logic        we;
  } crs_gpr_wr_t;

  typedef struct packed {
    logic        we;
    crs_sel_t    sel;
    logic [31:0] data;
  } crs_sys_wr_t;

  typedef struct packed {
    logic        enter;
    logic        leave;
    logic [7:0]  vectorNum;
    logic [31:0] poppedStatus;
    logic [31:0] poppedPc;
  } crs_exc_t;

  typedef struct packed {
    logic [31:0] pushStatusAddr;
    logic [31:0] pushPcAddr;
    logic [31:0] vectorAddr;
  } crs_exc_out_t;

endpackage

//--- rtl/crs_gpr_bank.sv
// Purpose: Sixteen general registers with one shared port and a stack port
// Assumes: Caller merges core and bus writes onto the shared port
// Notes:   Stack port wins over the shared port for the stack register
module crs_gpr_bank
  import crs_pkg::*;
(
  input  wire logic                                     clock,
  input  wire logic                                     reset,
  input  wire crs_pkg::crs_gpr_wr_t                     wrPort,
  input  wire logic                                     spWe,
  input  wire logic [crs_pkg::CRS_DATA_W-1:0]           spData,
  output      logic [crs_pkg::CRS_GPR_NUM-1:0][31:0]    gprs
);
  typedef struct packed {
    logic [CRS_GPR_NUM-1:0][31:0] regs;
  } crs_bank_t;

  crs_bank_t                    bank_ff;
  crs_bank_t                    nxt_bank;
  logic [CRS_GPR_NUM-1:0][31:0] nxtEntry;

  for (genvar i = 0; i < CRS_GPR_NUM; i++) begin : g_entry
    always_comb begin
      nxtEntry[i] = bank_ff.regs[i];
      if (wrPort.we && wrPort.idx == CRS_IDX_W'(i)) begin
        nxtEntry[i] = wrPort.data;
      end
      if (spWe && CRS_STACK_GPR == CRS_IDX_W'(i)) begin
        nxtEntry[i] = spData;
      end
    end
  end

  always_comb begin
    nxt_bank.regs = nxtEntry;
  end

  // Contents are undefined after reset in the architecture; zero keeps simulation clean
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      bank_ff <= '0;
    end else begin
      bank_ff <= nxt_bank;
    end
  end

  assign gprs = bank_ff.regs;
endmodule // crs_gpr_bank

//--- rtl/crs_register_set.sv
// Purpose: Architectural register set of the core with a register bus view
// Assumes: Avalon-MM slave with waitrequest; vector table reached by a fetch port
// Notes:   Core ports win over bus writes to the same register in one cycle
// Notes on behaviour
// - sixteen general, three control, four system registers
// - general register zero acts as index register
// - register fifteen is stack for exception frames
// - global base forms peripheral transfer addresses
// - vector base locates the exception vector area
// - multiply results land in high/low registers
// - link holds return address; counter steers flow
// - stack pointer loaded from vector table after reset
// - program counter loaded from vector table after reset
// - status mask bits ones, reserved zero at reset
module crs_register_set
  import crs_pkg::*;
(
  input  wire logic                          clock,
  input  wire logic                          reset,
  // Register bus
  input  wire logic [crs_pkg::CRS_ADDR_W-1:0] address,
  input  wire logic                          read,
  input  wire logic                          write,
  input  wire logic [31:0]                   writedata,
  output      logic [31:0]                   readdata,
  output      logic                          waitrequest,
  // Vector table fetch after reset
  output      logic                          vecReq,
  output      logic [31:0]                   vecAddr,
  input  wire logic                          vecValid,
  input  wire logic [31:0]                   vecData,
  output      logic                          coreReady,
  // Core general register access
  input  wire logic [crs_pkg::CRS_IDX_W-1:0] rdIdxA,
  input  wire logic [crs_pkg::CRS_IDX_W-1:0] rdIdxB,
  output      logic [31:0]                   rdDataA,
  output      logic [31:0]                   rdDataB,
  input  wire crs_pkg::crs_gpr_wr_t          gprWr,
  output      logic [31:0]                   indexGpr,
  output      logic [31:0]                   stackPointer,
  // Core control and system register access
  input  wire crs_pkg::crs_sys_wr_t          sysWr,
  input  wire logic                          macWe,
  input  wire logic [31:0]                   macHighIn,
  input  wire logic [31:0]                   macLowIn,
  input  wire logic                          callWe,
  input  wire logic [31:0]                   callReturn,
  input  wire logic                          pcWe,
  input  wire logic [31:0]                   pcNext,
  input  wire logic                          gblUseIndex,
  input  wire logic [31:0]                   gblDisp,
  output      logic [31:0]                   gblEffAddr,
  input  wire crs_pkg::crs_exc_t             exc,
  output      crs_pkg::crs_exc_out_t         excOut,
  output      logic [31:0]                   statusWord,
  output      logic [31:0]                   globalBase,
  output      logic [31:0]                   vectorBase,
  output      logic [31:0]                   macHigh,
  output      logic [31:0]                   macLow,
  output      logic [31:0]                   returnLink,
  output      logic [31:0]                   programCounter
);
  typedef struct packed {
    crs_state_t   state;
    logic         ready;
    logic         busWait;
    logic [31:0]  busData;
    logic [31:0]  vecAddr;
    logic         vecReq;
    logic [31:0]  rdA;
    logic [31:0]  rdB;
    logic [31:0]  gblEff;
    crs_exc_out_t excOut;
    logic [31:0]  status;
    logic [31:0]  gblBase;
    logic [31:0]  vector;
    logic [31:0]  macHi;
    logic [31:0]  macLo;
    logic [31:0]  link;
    logic [31:0]  pc;
  } crs_state_s_t;

  crs_state_s_t                 s_ff;
  crs_state_s_t                 nxt_s;
  logic [CRS_GPR_NUM-1:0][31:0] gprs;
  crs_gpr_wr_t                  bankWr;
  logic                         spWe;
  logic [31:0]                  spData;
  logic                         busGo;
  logic                         busWr;
  logic [CRS_IDX_W-1:0]         busIdx;
  logic                         busIsGpr;
  logic [31:0]                  busRead;

  crs_gpr_bank u_bank (
    .clock  (clock),
    .reset  (reset),
    .wrPort (bankWr),
    .spWe   (spWe),
    .spData (spData),
    .gprs   (gprs)
  );

  always_comb begin
    busGo    = (read || write) && s_ff.busWait;
    busWr    = write && !s_ff.busWait;
    busIdx   = address[5:2];
    busIsGpr = (address <= CRS_OFS_GPR_LAST) && (address[1:0] == 2'b00);
    busRead  = CRS_ZERO;
    if (busIsGpr) begin
      busRead = gprs[busIdx];
    end else begin
      case (address)
        CRS_OFS_STATUS: begin
          busRead = s_ff.status;
        end
        CRS_OFS_GLOBAL: begin
          busRead = s_ff.gblBase;
        end
        CRS_OFS_VECTOR: begin
          busRead = s_ff.vector;
        end
        CRS_OFS_MACHI: begin
          busRead = s_ff.macHi;
        end
        CRS_OFS_MACLO: begin
          busRead = s_ff.macLo;
        end
        CRS_OFS_LINK: begin
          busRead = s_ff.link;
        end
        CRS_OFS_PC: begin
          busRead = s_ff.pc;
        end
        CRS_OFS_CORESTAT: begin
          busRead = {31'h0, s_ff.state == CRS_ST_RUN};
        end
        default: begin
          busRead = CRS_ZERO;
        end
      endcase
    end
  end

  // Shared bank port: core has priority, bus write only lands when core is quiet
  always_comb begin
    bankWr = gprWr;
    if (!gprWr.we && busWr && busIsGpr) begin
      bankWr.we   = 1'b1;
      bankWr.idx  = busIdx;
      bankWr.data = writedata;
    end
    spWe   = 1'b0;
    spData = gprs[CRS_STACK_GPR];
    if (s_ff.state == CRS_ST_FETCH_SP && vecValid) begin
      spWe   = 1'b1;
      spData = vecData;
    end else if (exc.enter) begin
      spWe   = 1'b1;
      spData = gprs[CRS_STACK_GPR] - CRS_FRAME_BYTES;
    end else if (exc.leave) begin
      spWe   = 1'b1;
      spData = gprs[CRS_STACK_GPR] + CRS_FRAME_BYTES;
    end
  end

  always_comb begin
    nxt_s = s_ff;

    // Bus slave: one wait cycle, then a single low cycle with data
    nxt_s.busWait = !busGo;
    if (busGo) begin
      nxt_s.busData = busRead;
    end

    // Reset-time vector fetch; core held off until both words arrive
    case (s_ff.state)
      CRS_ST_FETCH_PC: begin
        nxt_s.vecReq  = 1'b1;
        nxt_s.vecAddr = CRS_VEC_PC_ADDR;
        if (vecValid) begin
          nxt_s.pc      = vecData;
          nxt_s.state   = CRS_ST_FETCH_SP;
          nxt_s.vecAddr = CRS_VEC_SP_ADDR;
        end
      end
      CRS_ST_FETCH_SP: begin
        if (vecValid) begin
          nxt_s.state  = CRS_ST_RUN;
          nxt_s.vecReq = 1'b0;
        end
      end
      CRS_ST_RUN: begin
        nxt_s.vecReq = 1'b0;
      end
      default: begin
        nxt_s.state = CRS_ST_FETCH_PC;
      end
    endcase

    // Bus writes first so that core updates below override them
    if (busWr) begin
      case (address)
        CRS_OFS_STATUS: begin
          nxt_s.status = writedata & CRS_SW_IMPL;
        end
        CRS_OFS_GLOBAL: begin
          nxt_s.gblBase = writedata;
        end
        CRS_OFS_VECTOR: begin
          nxt_s.vector = writedata;
        end
        CRS_OFS_MACHI: begin
          nxt_s.macHi = writedata;
        end
        CRS_OFS_MACLO: begin
          nxt_s.macLo = writedata;
        end
        CRS_OFS_LINK: begin
          nxt_s.link = writedata;
        end
        default: begin
          nxt_s.link = nxt_s.link;
        end
      endcase
    end

    if (sysWr.we) begin
      case (sysWr.sel)
        CRS_SEL_STATUS: begin
          nxt_s.status = sysWr.data & CRS_SW_IMPL;
        end
        CRS_SEL_GLOBAL: begin
          nxt_s.gblBase = sysWr.data;
        end
        CRS_SEL_VECTOR: begin
          nxt_s.vector = sysWr.data;
        end
        CRS_SEL_MACHI: begin
          nxt_s.macHi = sysWr.data;
        end
        CRS_SEL_MACLO: begin
          nxt_s.macLo = sysWr.data;
        end
        CRS_SEL_LINK: begin
          nxt_s.link = sysWr.data;
        end
        default: begin
          nxt_s.link = nxt_s.link;
        end
      endcase
    end
    if (macWe) begin
      nxt_s.macHi = macHighIn;
      nxt_s.macLo = macLowIn;
    end
    if (callWe) begin
      nxt_s.link = callReturn;
    end
    if (s_ff.state == CRS_ST_RUN && pcWe) begin
      nxt_s.pc = pcNext;
    end

    // Exception return restores the frame the core popped off the stack
    if (exc.leave) begin
      nxt_s.status = exc.poppedStatus & CRS_SW_IMPL;
      nxt_s.pc     = exc.poppedPc;
    end

    // Frame slots sit just below the stack pointer; counter above status
    nxt_s.excOut.pushPcAddr     = gprs[CRS_STACK_GPR] - CRS_WORD_BYTES;
    nxt_s.excOut.pushStatusAddr = gprs[CRS_STACK_GPR] - CRS_FRAME_BYTES;
    nxt_s.excOut.vectorAddr     = s_ff.vector + {22'h0, exc.vectorNum, 2'b00};

    // Index register replaces the displacement in the indexed form
    nxt_s.gblEff = s_ff.gblBase + (gblUseIndex ? gprs[CRS_INDEX_GPR] : gblDisp);

    // Registered so the core start flag leaves a flop like every other output
    nxt_s.ready = (nxt_s.state == CRS_ST_RUN);

    nxt_s.rdA = gprs[rdIdxA];
    nxt_s.rdB = gprs[rdIdxB];
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s_ff         <= '0;
      s_ff.state   <= CRS_ST_FETCH_PC;
      s_ff.busWait <= 1'b1;
      s_ff.status  <= CRS_SW_RESET;
      s_ff.vector  <= CRS_VECTOR_RESET;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign readdata       = s_ff.busData;
  assign waitrequest    = s_ff.busWait;
  assign vecReq         = s_ff.vecReq;
  assign vecAddr        = s_ff.vecAddr;
  assign coreReady      = s_ff.ready;
  assign rdDataA        = s_ff.rdA;
  assign rdDataB        = s_ff.rdB;
  assign indexGpr       = gprs[CRS_INDEX_GPR];
  assign stackPointer   = gprs[CRS_STACK_GPR];
  assign gblEffAddr     = s_ff.gblEff;
  assign excOut         = s_ff.excOut;
  assign statusWord     = s_ff.status;
  assign globalBase     = s_ff.gblBase;
  assign vectorBase     = s_ff.vector;
  assign macHigh        = s_ff.macHi;
  assign macLow         = s_ff.macLo;
  assign returnLink     = s_ff.link;
  assign programCounter = s_ff.pc;
endmodule // crs_register_set

//--- test/crs_register_set_monitor.sv
// Purpose: Port level checks of the core register set
// Assumes: One clock, asynchronous active high reset
// Notes:   Judges only what the design drives
module crs_register_set_monitor
  import crs_pkg::*;
(
  input wire logic                  clock,
  input wire logic                  reset,
  input wire logic                  read,
  input wire logic                  write,
  input wire logic                  waitrequest,
  input wire logic                  vecReq,
  input wire logic [31:0]           vecAddr,
  input wire logic                  vecValid,
  input wire logic [31:0]           vecData,
  input wire logic                  coreReady,
  input wire crs_pkg::crs_gpr_wr_t  gprWr,
  input wire logic [31:0]           indexGpr,
  input wire logic [31:0]           stackPointer,
  input wire logic                  macWe,
  input wire logic [31:0]           macHighIn,
  input wire logic [31:0]           macLowIn,
  input wire logic                  callWe,
  input wire logic [31:0]           callReturn,
  input wire logic                  gblUseIndex,
  input wire logic [31:0]           gblDisp,
  input wire logic [31:0]           gblEffAddr,
  input wire crs_pkg::crs_exc_t     exc,
  input wire crs_pkg::crs_exc_out_t excOut,
  input wire logic [31:0]           statusWord,
  input wire logic [31:0]           globalBase,
  input wire logic [31:0]           vectorBase,
  input wire logic [31:0]           macHigh,
  input wire logic [31:0]           macLow,
  input wire logic [31:0]           returnLink,
  input wire logic [31:0]           programCounter
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  chk_wait_pulse: assert property (
    (read || write) && waitrequest |=> !waitrequest ##1 waitrequest) else $error("bus answer not one cycle");
  chk_index_load: assert property (
    gprWr.we && gprWr.idx == CRS_INDEX_GPR |=> indexGpr == $past(gprWr.data)) else $error("index register lost");
  chk_exc_enter: assert property (
    exc.enter && !exc.leave |=> stackPointer == $past(stackPointer) - 32'h8
      && excOut.pushPcAddr == $past(stackPointer) - 32'h4) else $error("stack frame wrong");
  chk_exc_leave: assert property (
    exc.leave |=> programCounter == $past(exc.poppedPc)
      && statusWord == ($past(exc.poppedStatus) & CRS_SW_IMPL)) else $error("frame restore wrong");
  chk_global_addr: assert property (
    coreReady |=> gblEffAddr == $past(globalBase) + ($past(gblUseIndex) ? $past(indexGpr) : $past(gblDisp)))
    else $error("global base address wrong");
  chk_vector_area: assert property (
    coreReady |=> excOut.vectorAddr == $past(vectorBase) + {22'h0, $past(exc.vectorNum), 2'b00})
    else $error("vector address wrong");
  chk_mac_load: assert property (
    macWe |=> macHigh == $past(macHighIn) && macLow == $past(macLowIn)) else $error("mac load wrong");
  chk_link_load: assert property (
    callWe |=> returnLink == $past(callReturn)) else $error("return link wrong");
  chk_sp_fetch: assert property (
    vecReq && vecValid && vecAddr == 32'h4 |=> stackPointer == $past(vecData) && !vecReq && coreReady)
    else $error("stack pointer fetch wrong");
  chk_pc_fetch: assert property (
    vecReq && vecValid && vecAddr == 32'h0 |=> programCounter == $past(vecData)) else $error("pc fetch wrong");
  chk_reset_vals: assert property (
    $rose(vecReq) |-> statusWord[7:4] == 4'hf && (statusWord & ~CRS_SW_IMPL) == 32'h0
      && vectorBase == 32'h0) else $error("reset values wrong");
endmodule // crs_register_set_monitor

//--- test/test_crs_register_set.sv
// Purpose: Self-checking bench of the core register set
// Assumes: Bus master waits on waitrequest; core strobes last one cycle, pcWe two
// Notes:   Runs twice so the fetch is seen after a mid-run reset
module test_crs_register_set
  import crs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic         clock, reset, read, write, waitrequest, vecReq, vecValid, coreReady;
  logic         macWe, callWe, pcWe, gblUseIndex;
  logic [7:0]   address;
  logic [3:0]   rdIdxA, rdIdxB;
  logic [31:0]  writedata, readdata, vecAddr, vecData, rdDataA, rdDataB, indexGpr, stackPointer;
  logic [31:0]  macHighIn, macLowIn, callReturn, pcNext, gblDisp, gblEffAddr, statusWord, globalBase;
  logic [31:0]  vectorBase, macHigh, macLow, returnLink, programCounter;
  logic [31:0]  r [6];
  logic [31:0]  mdl [24];
  logic [31:0]  seed = 32'h87e0;
  crs_gpr_wr_t  gprWr;
  crs_sys_wr_t  sysWr;
  crs_exc_t     exc;
  crs_exc_out_t excOut;
  int           failCount = 0;
  int           numChecks = 0;

  crs_register_set uut (.*);
  always #25 clock = ~clock;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp) begin
      failCount++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Holds the request until waitrequest is seen low; only the watchdog ends a dead wait
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clock);
    address <= a;
    write <= w;
    read <= !w;
    writedata <= d;
    do begin
      @(posedge clock);
    end while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic busRw(input logic w, input logic [7:0] a);
    logic [31:0] d, q;
    d = rnd();
    bus(w, a, d, q);
    if (!w) chk(q, a <= CRS_OFS_CORESTAT ? mdl[a[7:2]] : 32'h0);
    else if (a == CRS_OFS_STATUS) mdl[16] = d & CRS_SW_IMPL;
    else if (a < CRS_OFS_PC) mdl[a[7:2]] = d;
  endtask

  task automatic results();
    $display("checks=%0d mismatches=%0d", numChecks, failCount);
    if (failCount == 0 && numChecks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (8000) @(posedge clock);
    failCount++;
    results();
  end

  initial begin
    {clock, read, write, vecValid, macWe, callWe, pcWe, gblUseIndex, address, rdIdxA, rdIdxB} = '0;
    {writedata, vecData, macHighIn, macLowIn, callReturn, pcNext, gblDisp} = '0;
    {gprWr, sysWr, exc} = '0;
    reset = 1'b1;
    for (int p = 0; p < 2; p++) begin
      repeat (8) @(posedge clock);
      reset <= 1'b0;
      foreach (mdl[i]) mdl[i] = 32'h0;
      mdl[16] = CRS_SW_RESET;
      foreach (r[i]) r[i] = rnd();
      @(negedge clock);
      chk(statusWord, CRS_SW_RESET);
      chk(vectorBase, CRS_VECTOR_RESET);
      // Vector fetch, answered late on purpose
      while (vecReq !== 1'b1) @(posedge clock);
      chk(vecAddr, CRS_VEC_PC_ADDR);
      vecValid <= 1'b1;
      vecData <= r[0];
      @(posedge clock);
      vecValid <= 1'b0;
      vecData <= ~r[0];
      @(negedge clock);
      chk(programCounter, r[0]);
      chk(vecAddr, CRS_VEC_SP_ADDR);
      repeat (2) @(posedge clock);
      vecValid <= 1'b1;
      vecData <= r[1];
      @(posedge clock);
      vecValid <= 1'b0;
      vecData <= ~r[1];
      @(negedge clock);
      chk(stackPointer, r[1]);
      chk({31'h0, coreReady}, 32'h1);
      mdl[22] = r[0];
      mdl[15] = r[1];
      mdl[23] = 32'h1;
      $display("test fetch done");
      // Every slot written, then read back, past the end of the map too
      for (int a = 0; a <= 'h60; a += 4) busRw(1'b1, a[7:0]);
      for (int a = 0; a <= 'h60; a += 4) busRw(1'b0, a[7:0]);
      chk(programCounter, mdl[22]);
      $display("test bus done");
      foreach (r[i]) r[i] = rnd();
      @(posedge clock);
      {macWe, callWe, gblUseIndex} <= 3'b110;
      {macHighIn, macLowIn, callReturn, gblDisp} <= {r[0], r[1], r[2], r[5]};
      gprWr <= '{idx: CRS_INDEX_GPR, data: r[3], we: 1'b1};
      sysWr <= '{we: 1'b1, sel: CRS_SEL_GLOBAL, data: r[4]};
      rdIdxA <= CRS_INDEX_GPR;
      rdIdxB <= CRS_STACK_GPR;
      @(posedge clock);
      {macWe, callWe, gprWr.we, sysWr.we, gblUseIndex} <= 5'b00001;
      @(negedge clock);
      chk(macHigh, r[0]);
      chk(macLow, r[1]);
      chk(returnLink, r[2]);
      chk(gblEffAddr, mdl[17] + r[5]);
      chk(globalBase, r[4]);
      chk(indexGpr, r[3]);
      @(negedge clock);
      chk(gblEffAddr, r[4] + r[3]);
      chk(rdDataA, r[3]);
      chk(rdDataB, mdl[15]);
      $display("test core done");
      // Exception entry, then a return that beats a same-cycle jump
      @(posedge clock);
      exc <= '{enter: 1'b1, leave: 1'b0, vectorNum: r[0][7:0], poppedStatus: r[1], poppedPc: r[2]};
      @(posedge clock);
      exc.enter <= 1'b0;
      @(negedge clock);
      chk(stackPointer, mdl[15] - CRS_FRAME_BYTES);
      chk(excOut.pushPcAddr, mdl[15] - CRS_WORD_BYTES);
      chk(excOut.pushStatusAddr, mdl[15] - CRS_FRAME_BYTES);
      chk(excOut.vectorAddr, mdl[18] + {22'h0, r[0][7:0], 2'b00});
      @(posedge clock);
      {exc.leave, pcWe, pcNext} <= {2'b11, r[3]};
      @(posedge clock);
      exc.leave <= 1'b0;
      pcNext <= r[4];
      @(negedge clock);
      chk(programCounter, r[2]);
      chk(statusWord, r[1] & CRS_SW_IMPL);
      chk(stackPointer, mdl[15]);
      @(posedge clock);
      pcWe <= 1'b0;
      @(negedge clock);
      chk(programCounter, r[4]);
      $display("test exception done");
      // Every control and system register but the program counter through the core write port
      for (int s = 0; s < 6; s++) begin
        @(posedge clock);
        sysWr <= '{we: 1'b1, sel: crs_sel_t'(s), data: r[s]};
        @(posedge clock);
        sysWr.we <= 1'b0;
        @(negedge clock);
        case (s)
          0: chk(statusWord, r[0] & CRS_SW_IMPL);
          1: chk(globalBase, r[1]);
          2: chk(vectorBase, r[2]);
          3: chk(macHigh, r[3]);
          4: chk(macLow, r[4]);
          default: chk(returnLink, r[5]);
        endcase
      end
      $display("test system writes done");
      @(posedge clock);
      reset <= 1'b1;
    end
    results();
  end
endmodule // test_crs_register_set

bind crs_register_set crs_register_set_monitor mon (.*);
